// ==== sqs_params.svh ====
`ifndef SQS_PARAMS_SVH
`define SQS_PARAMS_SVH

// entry word addresses on the register port
`define SQS_ENTRY1_OFFSET 6'h21
`define SQS_ENTRY2_OFFSET 6'h22
`define SQS_ENTRY3_OFFSET 6'h23

// entry reset words
`define SQS_ENTRY1_RESET 16'h4211
`define SQS_ENTRY2_RESET 16'h4422
`define SQS_ENTRY3_RESET 16'h4633

// field positions inside an entry word
`define SQS_DIR_BIT 15
`define SQS_ADDR_HI 14
`define SQS_ADDR_LO 9
`define SQS_RET_BIT 8
`define SQS_B_HI    7
`define SQS_B_LO    4
`define SQS_A_HI    3
`define SQS_A_LO    0

// idle value of the read data port
`define SQS_RDATA_IDLE 16'h0000

`endif

// ==== sqs_pkg.sv ====
package sqs_pkg;

    // one stack entry as held in flops
    typedef struct packed {
        logic       ret;      // return_to_first_entry
        logic [3:0] b_pick;   // converter b channel
        logic [3:0] a_pick;   // converter a channel
    } sqs_entry_s;

    // sequencer position, entry 0 to entry 3
    typedef enum logic [1:0] {
        SQS_SLOT0 = 2'b00,
        SQS_SLOT1 = 2'b01,
        SQS_SLOT2 = 2'b10,
        SQS_SLOT3 = 2'b11
    } sqs_slot_e;

    // state of the top module
    typedef struct packed {
        sqs_slot_e   slot;    // current stack entry
        logic [3:0]  a_pick;  // converter a channel output
        logic [3:0]  b_pick;  // converter b channel output
        logic [15:0] rdata;   // read answer
    } sqs_top_s;

    typedef logic [15:0] sqs_word_t;
    typedef logic [5:0]  sqs_addr_t;

endpackage

// ==== sqs_entry.sv ====
`timescale 1ns/1ps
`include "sqs_params.svh"

// one stack entry register with its own address check
module sqs_entry #(
    parameter logic [5:0]  ENTRY_ADDR = 6'h21,
    parameter logic [15:0] RESET_WORD = 16'h4211
) (
    input  wire logic            core_clk,
    input  wire logic            rst_sync_n,
    input  wire logic            reg_wr,
    input  wire sqs_pkg::sqs_addr_t reg_addr,
    input  wire sqs_pkg::sqs_word_t reg_wdata,
    output sqs_pkg::sqs_entry_s  entry,
    output sqs_pkg::sqs_word_t   word
);
    import sqs_pkg::*;

    sqs_entry_s state;      // stored fields
    sqs_entry_s next_state; // next fields
    logic       take;       // write accepted this cycle

    // reset image of the stored fields
    localparam sqs_entry_s RESET_ENTRY = RESET_WORD[`SQS_RET_BIT:`SQS_A_LO];

    // accept a write only with direction set and own address inside the word
    always_comb begin
        take = reg_wr && (reg_addr == ENTRY_ADDR)
            && reg_wdata[`SQS_DIR_BIT]
            && (reg_wdata[`SQS_ADDR_HI:`SQS_ADDR_LO] == ENTRY_ADDR);
        next_state = state;
        if (take) begin
            next_state.ret    = reg_wdata[`SQS_RET_BIT];
            next_state.b_pick = reg_wdata[`SQS_B_HI:`SQS_B_LO];
            next_state.a_pick = reg_wdata[`SQS_A_HI:`SQS_A_LO];
        end
    end

    // field flops
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state <= RESET_ENTRY;
        end else begin
            state <= next_state;
        end
    end

    // direction bit reads zero, address field reads own address
    assign entry = state;
    assign word  = {1'b0, ENTRY_ADDR, state};
endmodule

// ==== sqs_seq_stack.sv ====
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`include "sqs_params.svh"

module sqs_seq_stack (
    input  wire logic               core_clk,
    input  wire logic               rst_n,
    input  wire sqs_pkg::sqs_addr_t reg_addr,
    input  wire sqs_pkg::sqs_word_t reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output sqs_pkg::sqs_word_t      reg_rdata,
    input  wire logic               conv_done,
    input  wire logic               entry0_return,
    input  wire logic [3:0]         entry0_b_pick,
    input  wire logic [3:0]         entry0_a_pick,
    output sqs_pkg::sqs_slot_e      seq_slot,
    output logic [3:0]              converter_a_channel_pick,
    output logic [3:0]              converter_b_channel_pick
);
    import sqs_pkg::*;

    // entry addresses and reset words, index 1 to 3
    localparam logic [3:1][5:0]  ENTRY_ADDR = {`SQS_ENTRY3_OFFSET,
                                               `SQS_ENTRY2_OFFSET,
                                               `SQS_ENTRY1_OFFSET};
    localparam logic [3:1][15:0] ENTRY_RST  = {`SQS_ENTRY3_RESET,
                                               `SQS_ENTRY2_RESET,
                                               `SQS_ENTRY1_RESET};

    logic        rst_meta_n;   // reset synchroniser first stage
    logic        rst_sync_n;   // released reset used by all logic
    sqs_entry_s  ent [1:3];    // stored entry fields
    sqs_word_t   ent_word [1:3]; // read images of the entries
    sqs_top_s    state;        // registered state
    sqs_top_s    next_state;   // next state
    sqs_slot_e   slot_after;   // slot after a finished conversion
    logic        cur_ret;      // return bit of the current entry
    logic [3:0]  sel_a;        // converter a pick of next slot
    logic [3:0]  sel_b;        // converter b pick of next slot
    sqs_word_t   rd_word;      // word selected by read address

    // reset release through two flops
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    // the three entry registers
    genvar k;
    generate
        for (k = 1; k <= 3; k++) begin : g_entry
            sqs_entry #(
                .ENTRY_ADDR (ENTRY_ADDR[k]),
                .RESET_WORD (ENTRY_RST[k])
            ) u_entry (
                .core_clk   (core_clk),
                .rst_sync_n (rst_sync_n),
                .reg_wr     (reg_wr),
                .reg_addr   (reg_addr),
                .reg_wdata  (reg_wdata),
                .entry      (ent[k]),
                .word       (ent_word[k])
            );
        end
    endgenerate

    // return bit of the entry now in use
    always_comb begin
        unique case (state.slot)
            SQS_SLOT0: cur_ret = entry0_return;
            SQS_SLOT1: cur_ret = ent[1].ret;
            SQS_SLOT2: cur_ret = ent[2].ret;
            SQS_SLOT3: cur_ret = ent[3].ret;
        endcase
    end

    // next position once a conversion is finished
    always_comb begin
        slot_after = SQS_SLOT0;
        if (cur_ret) begin
            slot_after = SQS_SLOT0;
        end else begin
            // step forward, wrap past the last entry held here
            unique case (state.slot)
                SQS_SLOT0: slot_after = SQS_SLOT1;
                SQS_SLOT1: slot_after = SQS_SLOT2;
                SQS_SLOT2: slot_after = SQS_SLOT3;
                SQS_SLOT3: slot_after = SQS_SLOT0;
            endcase
        end
    end

    // read mux, unmapped addresses answer zero
    always_comb begin
        rd_word = `SQS_RDATA_IDLE;
        if (reg_addr == ENTRY_ADDR[1]) begin
            rd_word = ent_word[1];
        end else if (reg_addr == ENTRY_ADDR[2]) begin
            rd_word = ent_word[2];
        end else if (reg_addr == ENTRY_ADDR[3]) begin
            rd_word = ent_word[3];
        end
    end

    // next state: slot, channel picks and read answer
    always_comb begin
        next_state = state;
        if (conv_done) begin
            next_state.slot = slot_after;
        end
        // channel pair taken from the entry the sequencer points at
        unique case (next_state.slot)
            SQS_SLOT0: begin
                sel_a = entry0_a_pick;
                sel_b = entry0_b_pick;
            end
            SQS_SLOT1: begin
                sel_a = ent[1].a_pick;
                sel_b = ent[1].b_pick;
            end
            SQS_SLOT2: begin
                sel_a = ent[2].a_pick;
                sel_b = ent[2].b_pick;
            end
            SQS_SLOT3: begin
                sel_a = ent[3].a_pick;
                sel_b = ent[3].b_pick;
            end
        endcase
        next_state.a_pick = sel_a;
        next_state.b_pick = sel_b;
        // answer stands only in the cycle after the read strobe
        if (reg_rd) begin
            next_state.rdata = rd_word;
        end else begin
            next_state.rdata = `SQS_RDATA_IDLE;
        end
    end

    // state flops
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state.slot   <= SQS_SLOT0;
            state.a_pick <= 4'h0;
            state.b_pick <= 4'h0;
            state.rdata  <= `SQS_RDATA_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // outputs straight from flops
    assign reg_rdata                = state.rdata;
    assign seq_slot                 = state.slot;
    assign converter_a_channel_pick = state.a_pick;
    assign converter_b_channel_pick = state.b_pick;

    // helper: pick of the current slot from live entries
    logic [3:0] now_a;  // converter a pick of current slot
    logic [3:0] now_b;  // converter b pick of current slot
    always_comb begin
        unique case (state.slot)
            SQS_SLOT0: begin
                now_a = entry0_a_pick;
                now_b = entry0_b_pick;
            end
            SQS_SLOT1: begin
                now_a = ent[1].a_pick;
                now_b = ent[1].b_pick;
            end
            SQS_SLOT2: begin
                now_a = ent[2].a_pick;
                now_b = ent[2].b_pick;
            end
            SQS_SLOT3: begin
                now_a = ent[3].a_pick;
                now_b = ent[3].b_pick;
            end
        endcase
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_sync_n);

    // read request to a stack entry
    sequence entry_read_s;
        reg_rd && (reg_addr >= `SQS_ENTRY1_OFFSET) && (reg_addr <= `SQS_ENTRY3_OFFSET);
    endsequence

    // accepted write to entry two
    sequence entry2_write_s;
        reg_wr && reg_wdata[15] && (reg_addr == `SQS_ENTRY2_OFFSET)
            && (reg_wdata[14:9] == `SQS_ENTRY2_OFFSET);
    endsequence

    // finished conversion with return clear, not at the last slot
    sequence step_s;
        conv_done && !cur_ret && (state.slot != SQS_SLOT3);
    endsequence

    // read of an entry shows direction zero and the address read
    read_dir_a: assert property (entry_read_s |=> (reg_rdata[15] == 1'b0))
        else $error("entry read shows direction bit set");

    read_addr_a: assert property (entry_read_s |=> (reg_rdata[14:9] == $past(reg_addr)))
        else $error("entry read address field wrong");

    // a write with direction zero leaves every entry unchanged
    dir_read_a: assert property (reg_wr && !reg_wdata[15] |=>
        ($stable(ent_word[1]) && $stable(ent_word[2]) && $stable(ent_word[3])))
        else $error("write with read direction changed an entry");

    // a write with a foreign address field leaves entry two unchanged
    addr_check_a: assert property (reg_wr && (reg_addr == `SQS_ENTRY2_OFFSET)
        && (reg_wdata[14:9] != `SQS_ENTRY2_OFFSET) |=> $stable(ent_word[2]))
        else $error("entry two took a write without its own address");

    // accepted write to entry two lands and reads back two cycles later
    write_back_a: assert property (entry2_write_s ##1 (reg_rd && reg_addr == `SQS_ENTRY2_OFFSET)
        |=> (reg_rdata[8:0] == $past(reg_wdata[8:0], 2)))
        else $error("entry two lost written fields");

    // return clear steps to the following entry
    step_next_a: assert property (step_s |=> (state.slot == $past(state.slot) + 2'd1))
        else $error("sequencer did not advance");

    // return set sends the sequencer to entry zero
    return_first_a: assert property (conv_done && cur_ret |=> (state.slot == SQS_SLOT0))
        else $error("sequencer did not return to entry zero");

    // no finished conversion, no movement
    hold_slot_a: assert property (!conv_done |=> $stable(state.slot))
        else $error("sequencer moved without a finished conversion");

    // converter picks follow the entry in use when nothing changed, once out of reset a cycle
    pick_b_a: assert property (##1 ($stable(entry0_b_pick) && !$past(reg_wr) && $past(rst_sync_n))
        |-> (converter_b_channel_pick == now_b))
        else $error("converter b pick differs from current entry");

    pick_a_a: assert property (##1 ($stable(entry0_a_pick) && !$past(reg_wr) && $past(rst_sync_n))
        |-> (converter_a_channel_pick == now_a))
        else $error("converter a pick differs from current entry");

    // reset images of the three entries
    reset_vals_a: assert property ($rose(rst_sync_n) |->
        (ent_word[2] == `SQS_ENTRY2_RESET) && (ent_word[3] == `SQS_ENTRY3_RESET)
        && (ent_word[1] == `SQS_ENTRY1_RESET) && (state.slot == SQS_SLOT0))
        else $error("entry or slot wrong after reset");

    // read data idle when no read came a cycle before
    rdata_idle_a: assert property (!reg_rd |=> (reg_rdata == `SQS_RDATA_IDLE))
        else $error("read data not idle");

    // reads of unmapped addresses answer the idle word
    unmapped_read_a: assert property (reg_rd
        && ((reg_addr < `SQS_ENTRY1_OFFSET) || (reg_addr > `SQS_ENTRY3_OFFSET))
        |=> (reg_rdata == `SQS_RDATA_IDLE))
        else $error("unmapped read answered non-zero");

    // writes to unmapped addresses leave every entry unchanged
    foreign_write_a: assert property (reg_wr
        && ((reg_addr < `SQS_ENTRY1_OFFSET) || (reg_addr > `SQS_ENTRY3_OFFSET))
        |=> ($stable(ent_word[1]) && $stable(ent_word[2]) && $stable(ent_word[3])))
        else $error("write to an unmapped address changed an entry");

    // well formed write lands in entry one
    entry1_write_a: assert property (reg_wr && reg_wdata[`SQS_DIR_BIT] && (reg_addr == `SQS_ENTRY1_OFFSET)
        && (reg_wdata[`SQS_ADDR_HI:`SQS_ADDR_LO] == `SQS_ENTRY1_OFFSET)
        |=> (ent_word[1][`SQS_RET_BIT:`SQS_A_LO] == $past(reg_wdata[`SQS_RET_BIT:`SQS_A_LO])))
        else $error("entry one lost written fields");

    // well formed write lands in entry three
    entry3_write_a: assert property (reg_wr && reg_wdata[`SQS_DIR_BIT] && (reg_addr == `SQS_ENTRY3_OFFSET)
        && (reg_wdata[`SQS_ADDR_HI:`SQS_ADDR_LO] == `SQS_ENTRY3_OFFSET)
        |=> (ent_word[3][`SQS_RET_BIT:`SQS_A_LO] == $past(reg_wdata[`SQS_RET_BIT:`SQS_A_LO])))
        else $error("entry three lost written fields");

    // a step from entry one loads the picks of entry two
    step_pick_a: assert property (conv_done && !cur_ret && (state.slot == SQS_SLOT1)
        |=> ({converter_b_channel_pick, converter_a_channel_pick} == $past(ent_word[2][`SQS_B_HI:`SQS_A_LO])))
        else $error("step to entry two did not load its channel picks");

    // a return loads the picks of entry zero
    return_pick_a: assert property (conv_done && cur_ret
        |=> ({converter_b_channel_pick, converter_a_channel_pick} == {$past(entry0_b_pick), $past(entry0_a_pick)}))
        else $error("return did not load the entry zero picks");

    // first cycle out of reset loads the picks of entry zero
    release_pick_a: assert property ($rose(rst_sync_n)
        |=> ({converter_b_channel_pick, converter_a_channel_pick} == {$past(entry0_b_pick), $past(entry0_a_pick)}))
        else $error("picks not taken from entry zero after reset");

    // outputs still at their reset values when reset lets go
    reset_out_a: assert property ($rose(rst_sync_n)
        |-> (converter_a_channel_pick == 4'h0) && (converter_b_channel_pick == 4'h0) && (reg_rdata == `SQS_RDATA_IDLE))
        else $error("outputs not at reset values on release");
endmodule

// ==== sqs_host_model.sv ====
`timescale 1ns/1ps

// host side of the register port: one strobe a cycle, back to back allowed
module sqs_host_model (
    input  wire logic              core_clk,
    output sqs_pkg::sqs_addr_t     reg_addr,
    output sqs_pkg::sqs_word_t     reg_wdata,
    output logic                   reg_wr,
    output logic                   reg_rd
);
    import sqs_pkg::*;

    // bus parked at time zero
    initial begin
        reg_addr  = 6'h00;
        reg_wdata = 16'h0000;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // one write cycle with a raw word, called just after an edge
    task automatic write_raw(input sqs_addr_t a, input sqs_word_t d);
        reg_wr    <= 1'b1;
        reg_rd    <= 1'b0;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
    endtask

    // well formed write: direction bit set, own address in the word
    task automatic write_entry(input sqs_addr_t a, input logic [8:0] f);
        write_raw(a, {1'b1, a, f});
    endtask

    // one read cycle; the answer shows in the next cycle
    task automatic read(input sqs_addr_t a);
        reg_rd   <= 1'b1;
        reg_wr   <= 1'b0;
        reg_addr <= a;
        @(posedge core_clk);
    endtask

    // strobes down, released lines show inverted garbage
    task automatic idle();
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b0;
        reg_addr  <= ~reg_addr;
        reg_wdata <= ~reg_wdata;
        @(posedge core_clk);
    endtask
endmodule

// ==== adc_sequencer_stack_entries_bench.sv ====
`timescale 1ns/1ps

module adc_sequencer_stack_entries_bench;
    import sqs_pkg::*;

    logic        core_clk = 1'b0;            // 250 MHz
    logic        rst_n;                      // async, active low
    logic        conv_done;                  // conversion finished pulse
    logic        entry0_return;              // entry 0 held out here
    logic [3:0]  entry0_a_pick;
    logic [3:0]  entry0_b_pick;
    sqs_addr_t   reg_addr;
    sqs_word_t   reg_wdata;
    sqs_word_t   reg_rdata;
    logic        reg_wr;
    logic        reg_rd;
    sqs_slot_e   seq_slot;
    logic [3:0]  converter_a_channel_pick;
    logic [3:0]  converter_b_channel_pick;
    int          fails    = 0;
    int          compares = 0;
    logic [31:0] seed     = 32'h0404;        // lfsr state
    logic [8:0]  ent [1:3];                  // model of stored fields
    sqs_slot_e   slot_m;                     // model of the sequencer slot
    sqs_word_t   rq [$];                     // expected read answers
    sqs_word_t   sq [$];                     // expected slot and picks
    logic        rd_q = 1'b0;
    logic        cd_q = 1'b0;

    // clock
    always #2 core_clk = ~core_clk;

    sqs_seq_stack i_sqs_seq_stack (
        .core_clk                 (core_clk),
        .rst_n                    (rst_n),
        .reg_addr                 (reg_addr),
        .reg_wdata                (reg_wdata),
        .reg_wr                   (reg_wr),
        .reg_rd                   (reg_rd),
        .reg_rdata                (reg_rdata),
        .conv_done                (conv_done),
        .entry0_return            (entry0_return),
        .entry0_b_pick            (entry0_b_pick),
        .entry0_a_pick            (entry0_a_pick),
        .seq_slot                 (seq_slot),
        .converter_a_channel_pick (converter_a_channel_pick),
        .converter_b_channel_pick (converter_b_channel_pick)
    );

    sqs_host_model i_sqs_host_model (
        .core_clk  (core_clk),
        .reg_addr  (reg_addr),
        .reg_wdata (reg_wdata),
        .reg_wr    (reg_wr),
        .reg_rd    (reg_rd)
    );

    // 32-bit lfsr step
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // expected read word of entry k: direction reads 0, own address
    function automatic sqs_word_t word_of(input int k);
        return {1'b0, 6'h20 + 6'(k), ent[k]};
    endfunction

    // compare and count
    task automatic check(input sqs_word_t seen, input sqs_word_t exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // verdict and end of run
    task automatic complete_run();
        if (fails == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // read with the expected answer noted first
    task automatic rd(input sqs_addr_t a, input sqs_word_t exp);
        rq.push_back(exp);
        i_sqs_host_model.read(a);
    endtask

    // watcher: answers land one cycle after their strobe
    always @(posedge core_clk) begin
        if (rd_q) begin
            check(reg_rdata, rq.pop_front());
        end
        if (cd_q) begin
            check({6'h00, seq_slot, converter_b_channel_pick, converter_a_channel_pick}, sq.pop_front());
        end
        rd_q <= reg_rd;
        cd_q <= conv_done;
    end

    // hang guard, far beyond the few hundred cycles needed
    initial begin
        #20000;
        fails++;
        complete_run();
    end

    // main sequence
    initial begin
        int         k;
        sqs_addr_t  a;
        logic [8:0] f;
        logic       ret;
        rst_n         = 1'b0;
        conv_done     = 1'b0;
        entry0_return = 1'b0;
        entry0_a_pick = 4'h5;
        entry0_b_pick = 4'hA;
        ent[1]        = 9'h011;
        ent[2]        = 9'h022;
        ent[3]        = 9'h033;
        slot_m        = SQS_SLOT0;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
        check({6'h00, seq_slot, converter_b_channel_pick, converter_a_channel_pick}, {6'h00, SQS_SLOT0, 8'hA5});
        @(posedge core_clk);
        // reset words back to back, then unmapped neighbours
        rd(6'h21, 16'h4211);
        rd(6'h22, 16'h4422);
        rd(6'h23, 16'h4633);
        rd(6'h20, 16'h0000);
        rd(6'h24, 16'h0000);
        for (int r = 0; r < 6; r++) begin
            // random fields, then two malformed writes that must not land
            for (k = 1; k <= 3; k++) begin
                seed = lfsr_next(seed);
                a    = 6'h20 + 6'(k);
                f    = {seed[9] & seed[10], seed[7:0]};
                i_sqs_host_model.write_entry(a, f);
                ent[k] = f;
                rd(a, word_of(k));
                i_sqs_host_model.write_raw(a, {1'b0, a, ~f});
                i_sqs_host_model.write_raw(a, {1'b1, a ^ 6'h04, ~f});
                rd(a, word_of(k));
            end
            i_sqs_host_model.write_entry(6'h24, seed[8:0]);
            rd(6'h24, 16'h0000);
            i_sqs_host_model.idle();
            // conversions at random spacing, entry 0 moving meanwhile
            for (int i = 0; i < 30; i++) begin
                seed = lfsr_next(seed);
                ret  = seed[4] & seed[5];
                conv_done     <= seed[0] | seed[1];
                entry0_return <= ret;
                entry0_a_pick <= seed[11:8];
                entry0_b_pick <= seed[15:12];
                if (seed[0] | seed[1]) begin
                    if (slot_m != SQS_SLOT0) begin
                        ret = ent[int'(slot_m)][8];
                    end
                    slot_m = ret ? SQS_SLOT0 : sqs_slot_e'(slot_m + 2'd1);
                    sq.push_back({6'h00, slot_m, (slot_m == SQS_SLOT0) ? seed[15:8] : ent[int'(slot_m)][7:0]});
                end
                @(posedge core_clk);
            end
            conv_done <= 1'b0;
            @(posedge core_clk);
        end
        repeat (3) @(posedge core_clk);
        if (rq.size() != 0 || sq.size() != 0) begin
            fails++;
        end
        complete_run();
    end
endmodule
